// file: core/cascaded_pi_motor_loop.sv
// cascaded position, speed and current loops with feed-forward
`timescale 1ns/1ps
`default_nettype none
module cascaded_pi_motor_loop
  import pi_loop_pkg::*;
#(
  parameter int DW = 16
) (
  input  wire logic                 I_MCLK,
  input  wire logic                 I_RST,
  input  wire logic [7:0]           I_ADDR,
  input  wire logic [31:0]          I_WDATA,
  input  wire logic                 I_WR,
  input  wire logic                 I_RD,
  output logic      [31:0]          O_RDATA,
  input  wire logic signed [DW-1:0] I_POS_FB,
  input  wire logic signed [DW-1:0] I_VEL_FB,
  input  wire logic signed [DW-1:0] I_CUR_FB,
  input  wire logic                 I_STEP,
  input  wire logic                 I_DIR,
  input  wire logic signed [DW-1:0] I_RAMP_VEL,
  input  wire logic signed [DW-1:0] I_RAMP_ACC,
  output logic signed [DW-1:0]      O_PWM,
  output logic                      O_LOOP_CLOSED
);
  `include "pi_loop_defs.svh"
  localparam logic [15:0] TICK_LAST = 16'(`TICK_CYC - 1);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic signed [DW-1:0] fb_meta_reg [3];
  logic signed [DW-1:0] fb_reg      [3];
  logic [1:0]           step_meta_reg;
  logic [1:0]           step_sync_reg;
  logic                 step_last_reg;
  logic                 step_pulse;
  // a multi-bit feedback word may tear for one sample; sensors hold it
  always_ff @(posedge I_MCLK) begin
    fb_meta_reg[0] <= I_POS_FB;
    fb_meta_reg[1] <= I_VEL_FB;
    fb_meta_reg[2] <= I_CUR_FB;
    fb_reg         <= fb_meta_reg;
    step_meta_reg  <= {I_DIR, I_STEP};
    step_sync_reg  <= step_meta_reg;
    step_last_reg  <= step_sync_reg[0];
  end
  assign step_pulse = step_sync_reg[0] & ~step_last_reg;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [`CTRL_W-1:0] ctrl_reg;
  logic [DW-1:0]      target_reg;
  logic [DW-1:0]      vff_reg;
  logic [DW-1:0]      aff_reg;
  logic [DW-1:0]      inertia_reg;
  logic [DW-1:0]      uff_reg;
  logic [DW-1:0]      cd_mul_reg;
  logic [DW-1:0]      cd_div_reg;
  logic [DW-1:0]      kp_reg     [3];
  logic [DW-1:0]      leg_kp_reg [3];
  logic [DW-1:0]      emax_reg   [3];
  logic [DW-1:0]      ymax_reg   [3];
  logic [DW-1:0]      tn_reg     [3];
  logic [DW-1:0]      kp_eff     [3];
  logic               wr_ctrl;
  logic               in_loop;
  logic               in_leg;
  logic [1:0]         loop_idx;
  logic [1:0]         fld;
  logic               use_legacy;
  logic               sel_next;
  logic               convert;

  assign wr_ctrl  = I_WR && (I_ADDR == `A_CTRL);
  assign in_loop  = (I_ADDR[7:6] == 2'h0) && (I_ADDR[`LOOP_SEL] != 2'h0) && (I_ADDR[1:0] == 2'h0);
  assign in_leg   = (I_ADDR[`PAGE_SEL] == `PAGE_LEG) && (I_ADDR[`FLD_SEL] != 2'h3) && (I_ADDR[1:0] == 2'h0);
  assign loop_idx = I_ADDR[`LOOP_SEL] - 2'h1;
  assign fld      = I_ADDR[`FLD_SEL];
  assign use_legacy = ctrl_reg[`B_CLOSED] ? ctrl_reg[`B_CL_LEG] : ctrl_reg[`B_OL_LEG];
  assign sel_next   = I_WDATA[`B_CLOSED] ? I_WDATA[`B_CL_LEG] : I_WDATA[`B_OL_LEG];
  // clearing the active select stands in for the next power-up
  assign convert    = wr_ctrl && use_legacy && !sel_next;

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      ctrl_reg    <= `RST_CTRL;
      target_reg  <= '0;
      vff_reg     <= '0;
      aff_reg     <= '0;
      inertia_reg <= '0;
      uff_reg     <= `RST_UFF;
      cd_mul_reg  <= `RST_CD;
      cd_div_reg  <= `RST_CD;
    end else if (I_WR) begin
      unique case (I_ADDR)
        `A_CTRL:    ctrl_reg    <= I_WDATA[`CTRL_W-1:0];
        `A_TARGET:  target_reg  <= I_WDATA[DW-1:0];
        `A_VFF:     vff_reg     <= I_WDATA[DW-1:0];
        `A_AFF:     aff_reg     <= I_WDATA[DW-1:0];
        `A_INERTIA: inertia_reg <= I_WDATA[DW-1:0];
        `A_UFF:     uff_reg     <= I_WDATA[DW-1:0];
        `A_CD_MUL:  cd_mul_reg  <= I_WDATA[DW-1:0];
        `A_CD_DIV:  cd_div_reg  <= I_WDATA[DW-1:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  logic [3:0] mode;
  logic       closed;
  logic       is_torque;
  logic       is_velm;
  logic       pos_mode;
  logic       pos_en;
  logic       vff_en;
  logic       aff_en;
  logic       vel_bypass;
  assign mode      = ctrl_reg[`F_MODE];
  assign closed    = ctrl_reg[`B_CLOSED];
  assign is_torque = (mode == `M_PT) || (mode == `M_CST);
  assign is_velm   = (mode == `M_VL) || (mode == `M_PV) || (mode == `M_CSV);
  assign pos_mode  = (mode == `M_PP) || (mode == `M_HM) || (mode == `M_IP) ||
                     (mode == `M_CSP) || (mode == `M_CD);
  assign pos_en     = closed && (pos_mode || (is_velm && ctrl_reg[`B_POSVEL]));
  assign vff_en     = pos_en && (mode != `M_CSV);
  assign aff_en     = !is_torque;
  assign vel_bypass = is_torque && ctrl_reg[`B_NOLIM];

  // ---------------------------------------------------------------
  // control tick and cascade sequencer
  // ---------------------------------------------------------------
  seq_state_t state_reg;
  seq_state_t state_next;
  logic [15:0] tick_cnt_reg;
  logic        tick;
  assign tick = (tick_cnt_reg == TICK_LAST);
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (tick) begin
        state_next = ST_POS;
      end
      ST_POS:  state_next = ST_VEL;
      ST_VEL:  state_next = ST_CUR;
      ST_CUR:  state_next = ST_IDLE;
    endcase
  end
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      tick_cnt_reg <= 16'h0;
      state_reg    <= ST_IDLE;
    end else begin
      tick_cnt_reg <= tick ? 16'h0 : tick_cnt_reg + 16'h1;
      state_reg    <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // set points and feed-forward
  // ---------------------------------------------------------------
  logic signed [DW-1:0] cd_pos;
  logic signed [DW-1:0] y        [3];
  logic signed [DW-1:0] sp       [3];
  logic                 run      [3];
  logic                 hold     [3];
  wide_t                vff;
  wide_t                aff;
  wide_t                uff;
  wide_t                vel_full;
  wide_t                vel_c;
  wide_t                trq_lim;
  wide_t                cur_full;
  wide_t                cur_c;
  wide_t                pwm_c;
  logic signed [DW-1:0] target_s;

  step_scaler #(
    .W      (DW)
  ) u_steps (
    .i_clk  (I_MCLK),
    .i_rst  (I_RST),
    .i_step (step_pulse && (mode == `M_CD)),
    .i_dir  (step_sync_reg[1]),
    .i_mul  (cd_mul_reg),
    .i_div  (cd_div_reg),
    .o_pos  (cd_pos)
  );

  assign target_s = target_reg;
  assign sp[0]    = (mode == `M_CD) ? cd_pos : target_s;
  assign vff = vff_en ? (zx(vff_reg) * sx(I_RAMP_VEL)) / `PERMILLE : 64'sh0;
  assign aff = aff_en ? (zx(aff_reg) * zx(inertia_reg) * sx(I_RAMP_ACC)) / `PERMILLE : 64'sh0;
  // torque modes keep the speed loop as a limiter unless bypassed
  assign vel_full = pos_en ? sx(y[0]) + vff :
                    (is_torque ? zx(ymax_reg[0]) : sx(target_s));
  assign vel_c    = clamp64(vel_full, zx(ymax_reg[0]));
  assign sp[1]    = vel_c[DW-1:0];
  assign trq_lim  = (sx(y[1]) < sx(target_s)) ? sx(y[1]) : sx(target_s);
  assign cur_full = !closed ? zx(ymax_reg[1]) :
                    is_torque ? (vel_bypass ? sx(target_s) : trq_lim) :
                    sx(y[1]) + aff;
  assign cur_c    = clamp64(cur_full, zx(ymax_reg[1]));
  assign sp[2]    = cur_c[DW-1:0];
  // zero factor leaves no voltage term at all
  assign uff   = (uff_reg == '0) ? 64'sh0 : (zx(uff_reg) * sx(sp[2])) / `PERMILLE;
  assign pwm_c = clamp64(sx(y[2]) + uff, zx(ymax_reg[2]));

  assign run[0]  = (state_reg == ST_POS);
  assign run[1]  = (state_reg == ST_VEL);
  assign run[2]  = (state_reg == ST_CUR);
  assign hold[0] = !pos_en;
  assign hold[1] = !closed || vel_bypass;
  assign hold[2] = 1'b0;

  // ---------------------------------------------------------------
  // per-loop registers and stages
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_loop
      logic wr_here;
      assign wr_here   = I_WR && in_loop && (loop_idx == 2'(g));
      assign kp_eff[g] = use_legacy ? leg_kp_reg[g] : kp_reg[g];
      always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
          kp_reg[g]     <= `RST_KP;
          leg_kp_reg[g] <= `RST_LEG_KP;
          emax_reg[g]   <= `RST_EMAX;
          ymax_reg[g]   <= `RST_YMAX;
          tn_reg[g]     <= `RST_TN;
        end else begin
          if (convert) begin
            kp_reg[g] <= leg_kp_reg[g];
          end else if (wr_here && fld == `FLD_KP) begin
            kp_reg[g] <= I_WDATA[DW-1:0];
          end
          if (I_WR && in_leg && I_ADDR[`FLD_SEL] == 2'(g)) begin
            leg_kp_reg[g] <= I_WDATA[DW-1:0];
          end
          if (wr_here && fld == `FLD_EMAX) begin
            emax_reg[g] <= I_WDATA[DW-1:0];
          end
          if (wr_here && fld == `FLD_YMAX) begin
            ymax_reg[g] <= I_WDATA[DW-1:0];
          end
          if (wr_here && fld == `FLD_TN) begin
            tn_reg[g] <= I_WDATA[DW-1:0];
          end
        end
      end
      pi_stage #(
        .W      (DW)
      ) u_stage (
        .i_clk  (I_MCLK),
        .i_rst  (I_RST),
        .i_run  (run[g]),
        .i_hold (hold[g]),
        .i_sp   (sp[g]),
        .i_act  (fb_reg[g]),
        .i_kp   (kp_eff[g]),
        .i_emax (emax_reg[g]),
        .i_ymax (ymax_reg[g]),
        .i_tn   (tn_reg[g]),
        .o_y    (y[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // outputs and status
  // ---------------------------------------------------------------
  logic signed [DW-1:0] vel_sp_reg;
  logic signed [DW-1:0] cur_sp_reg;
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      vel_sp_reg    <= '0;
      cur_sp_reg    <= '0;
      O_PWM         <= '0;
      O_LOOP_CLOSED <= 1'b0;
    end else begin
      O_LOOP_CLOSED <= closed;
      if (run[1]) begin
        vel_sp_reg <= sp[1];
      end
      if (run[2]) begin
        cur_sp_reg <= sp[2];
      end
      // previous tick's current output plus fresh voltage term
      if (run[2]) begin
        O_PWM <= pwm_c[DW-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // register read-back
  // ---------------------------------------------------------------
  logic [31:0] loop_rd;
  logic [31:0] rd_next;
  assign loop_rd = (fld == `FLD_KP)   ? {16'h0, kp_reg[loop_idx]} :
                   (fld == `FLD_EMAX) ? {16'h0, emax_reg[loop_idx]} :
                   (fld == `FLD_YMAX) ? {16'h0, ymax_reg[loop_idx]} :
                                        {16'h0, tn_reg[loop_idx]};
  assign rd_next = in_loop                   ? loop_rd :
                   in_leg                    ? {16'h0, leg_kp_reg[I_ADDR[`FLD_SEL]]} :
                   (I_ADDR == `A_CTRL)       ? {14'h0, ctrl_reg} :
                   (I_ADDR == `A_TARGET)     ? {16'h0, target_reg} :
                   (I_ADDR == `A_VFF)        ? {16'h0, vff_reg} :
                   (I_ADDR == `A_AFF)        ? {16'h0, aff_reg} :
                   (I_ADDR == `A_INERTIA)    ? {16'h0, inertia_reg} :
                   (I_ADDR == `A_UFF)        ? {16'h0, uff_reg} :
                   (I_ADDR == `A_CD_MUL)     ? {16'h0, cd_mul_reg} :
                   (I_ADDR == `A_CD_DIV)     ? {16'h0, cd_div_reg} :
                   (I_ADDR == `A_ST_VEL)     ? {16'h0, vel_sp_reg} :
                   (I_ADDR == `A_ST_CUR)     ? {16'h0, cur_sp_reg} :
                   (I_ADDR == `A_ST_PWM)     ? {16'h0, O_PWM} :
                                               32'h0;
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_RDATA <= 32'h0;
    end else begin
      O_RDATA <= I_RD ? rd_next : 32'h0;
    end
  end
endmodule
`default_nettype wire

// file: common/pi_loop_defs.svh
// constants for the cascaded pi motor loop
`ifndef PI_LOOP_DEFS_SVH
`define PI_LOOP_DEFS_SVH
`define DW          16
`define CLK_NS      8
`define TICK_NS     8000
`define TICK_CYC    (`TICK_NS / `CLK_NS)
`define FULL_GAIN   64'sh3e8
`define PERMILLE    64'sh3e8
// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define A_CTRL      8'h00
`define A_TARGET    8'h04
`define A_VFF       8'h50
`define A_AFF       8'h54
`define A_INERTIA   8'h58
`define A_UFF       8'h5c
`define A_CD_MUL    8'h60
`define A_CD_DIV    8'h64
`define A_ST_VEL    8'h74
`define A_ST_CUR    8'h78
`define A_ST_PWM    8'h7c
`define PAGE_SEL    7:4
`define LOOP_SEL    5:4
`define FLD_SEL     3:2
`define PAGE_LEG    4'h4
`define FLD_KP      2'h0
`define FLD_EMAX    2'h1
`define FLD_YMAX    2'h2
`define FLD_TN      2'h3
// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define F_MODE      3:0
`define F_SUBMODE   15:8
`define B_CLOSED    8
`define B_POSVEL    9
`define B_NOLIM     13
`define B_CL_LEG    16
`define B_OL_LEG    17
`define CTRL_W      18
`define M_PP        4'h1
`define M_VL        4'h2
`define M_PV        4'h3
`define M_PT        4'h4
`define M_HM        4'h6
`define M_IP        4'h7
`define M_CSP       4'h8
`define M_CSV       4'h9
`define M_CST       4'ha
`define M_CD        4'hb
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_CTRL    18'h30000
`define RST_KP      16'h03e8
`define RST_LEG_KP  16'h01f4
`define RST_EMAX    16'h03e8
`define RST_YMAX    16'h7fff
`define RST_TN      16'h0000
`define RST_UFF     16'h03e8
`define RST_CD      16'h0001
`endif

// file: common/pi_loop_pkg.sv
// types and helpers shared by the motor loop files
package pi_loop_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_POS  = 4'h2,
    ST_VEL  = 4'h4,
    ST_CUR  = 4'h8
  } seq_state_t;
  typedef logic signed [63:0] wide_t;
  function automatic wide_t clamp64(input wide_t v, input wide_t lim);
    clamp64 = (v > lim) ? lim : ((v < -lim) ? -lim : v);
  endfunction
  function automatic wide_t zx(input logic [15:0] v);
    zx = $signed({48'h0, v});
  endfunction
  function automatic wide_t sx(input logic signed [15:0] v);
    sx = v;
  endfunction
endpackage

// file: core/pi_stage.sv
// one proportional-integral stage with clamped output
`timescale 1ns/1ps
`default_nettype none
module pi_stage
  import pi_loop_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic                i_run,
  input  wire logic                i_hold,
  input  wire logic signed [W-1:0] i_sp,
  input  wire logic signed [W-1:0] i_act,
  input  wire logic        [W-1:0] i_kp,
  input  wire logic        [W-1:0] i_emax,
  input  wire logic        [W-1:0] i_ymax,
  input  wire logic        [W-1:0] i_tn,
  output logic signed      [W-1:0] o_y
);
  `include "pi_loop_defs.svh"
  wide_t err;
  wide_t emax_s;
  wide_t ymax_s;
  wide_t tn_s;
  wide_t p_sat;
  wide_t i_part;
  wide_t acc_reg;
  wide_t acc_next;
  wide_t y_sat;
  assign err    = sx(i_sp) - sx(i_act);
  // zero deviation limit would divide by zero; treat it as one
  assign emax_s = (i_emax == '0) ? 64'sh1 : zx(i_emax);
  assign ymax_s = zx(i_ymax);
  assign tn_s   = zx(i_tn);
  // full gain at full deviation gives exactly the limit
  assign p_sat  = clamp64((err * zx(i_kp) * ymax_s) / (emax_s * `FULL_GAIN), ymax_s);
  // accumulator bounded so the integral alone never passes the limit
  assign acc_next = clamp64(acc_reg + p_sat, ymax_s * tn_s);
  assign i_part   = (i_tn == '0) ? 64'sh0 : acc_reg / tn_s;
  assign y_sat    = clamp64(p_sat + i_part, ymax_s);
  always_ff @(posedge i_clk) begin
    if (i_rst || i_hold) begin
      acc_reg <= 64'sh0;
      o_y     <= '0;
    end else if (i_run) begin
      acc_reg <= (i_tn == '0) ? 64'sh0 : acc_next;
      o_y     <= y_sat[W-1:0];
    end
  end
endmodule
`default_nettype wire

// file: core/step_scaler.sv
// step pulse scaler: multiplier over divider with kept remainder
`timescale 1ns/1ps
`default_nettype none
module step_scaler #(
  parameter int W = 16
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic                i_step,
  input  wire logic                i_dir,
  input  wire logic        [W-1:0] i_mul,
  input  wire logic        [W-1:0] i_div,
  output logic signed      [W-1:0] o_pos
);
  logic [31:0] frac_reg;
  logic [31:0] sum;
  logic [31:0] div_s;
  logic [31:0] quot;
  logic [31:0] rem;
  assign sum   = frac_reg + {16'h0, i_mul};
  assign div_s = (i_div == '0) ? 32'h1 : {16'h0, i_div};
  assign quot  = sum / div_s;
  // remainder is kept so fractional ratios do not drift
  assign rem   = sum % div_s;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      frac_reg <= 32'h0;
      o_pos    <= '0;
    end else if (i_step) begin
      frac_reg <= rem;
      o_pos    <= i_dir ? o_pos - $signed(quot[W-1:0]) : o_pos + $signed(quot[W-1:0]);
    end
  end
endmodule
`default_nettype wire

// file: verif/pi_loop_asserts.sv
// port checker for the cascaded motor loop
`timescale 1ns/1ps
`default_nettype none
module pi_loop_asserts
  import pi_loop_pkg::*;
#(
  parameter int DW = 16
) (
  input wire logic                 I_MCLK,
  input wire logic                 I_RST,
  input wire logic [7:0]           I_ADDR,
  input wire logic [31:0]          I_WDATA,
  input wire logic                 I_WR,
  input wire logic                 I_RD,
  input wire logic [31:0]          O_RDATA,
  input wire logic signed [DW-1:0] I_POS_FB,
  input wire logic signed [DW-1:0] I_VEL_FB,
  input wire logic signed [DW-1:0] I_CUR_FB,
  input wire logic                 I_STEP,
  input wire logic                 I_DIR,
  input wire logic signed [DW-1:0] I_RAMP_VEL,
  input wire logic signed [DW-1:0] I_RAMP_ACC,
  input wire logic signed [DW-1:0] O_PWM,
  input wire logic                 O_LOOP_CLOSED
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  // ---------------------------------------------------------------
  // helper state
  // ---------------------------------------------------------------
  logic        [15:0]   ymax_reg;
  logic        [9:0]    gap_reg;
  logic        [10:0]   up_reg;
  logic                 seen_reg;
  logic signed [DW-1:0] prev_reg;
  wire logic            chg = (prev_reg != O_PWM);
  always_ff @(posedge I_MCLK) begin
    prev_reg <= O_PWM;
    if (I_RST) begin
      ymax_reg <= 16'h7fff;
      gap_reg  <= 10'h0;
      up_reg   <= 11'h0;
      seen_reg <= 1'b0;
    end else begin
      // limit write can race a tick by a few cycles; the bench avoids that
      if (I_WR && I_ADDR == 8'h38) ymax_reg <= I_WDATA[15:0];
      gap_reg  <= chg ? 10'h0 : ((gap_reg == 10'h3e7) ? 10'h0 : gap_reg + 10'h1);
      up_reg   <= (up_reg == 11'h7ff) ? up_reg : up_reg + 11'h1;
      seen_reg <= seen_reg | chg;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  sequence s_rd(logic [7:0] a);
    I_RD && I_ADDR == a;
  endsequence
  property p_closed;
    logic b;
    (I_WR && I_ADDR == 8'h00, b = I_WDATA[8]) |-> ##2 O_LOOP_CLOSED == b;
  endproperty
  AST_RD_IDLE: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
    else $error("read data not idle");
  AST_RD_PWM: assert property (s_rd(8'h7c) |=> O_RDATA == {16'h0, $past(O_PWM)})
    else $error("pwm readback wrong");
  AST_RD_UPPER: assert property (I_RD && I_ADDR != 8'h00 |=> O_RDATA[31:16] == 16'h0)
    else $error("upper read bits set");
  AST_LOOP_CL: assert property (p_closed)
    else $error("closed loop flag wrong");
  AST_RST_OUT: assert property ($fell(I_RST) |-> O_PWM == 16'sh0 && !O_LOOP_CLOSED)
    else $error("outputs not reset");
  AST_PWM_TICK: assert property (seen_reg && chg |-> gap_reg == 10'h3e7)
    else $error("pwm changed off tick");
  AST_PWM_CLAMP: assert property (chg |-> O_PWM <= $signed({1'b0, ymax_reg}) && O_PWM >= -$signed({1'b0, ymax_reg}))
    else $error("pwm above limit");
  AST_FIRST_TICK: assert property (up_reg < 11'h3e8 |-> O_PWM == 16'sh0)
    else $error("pwm before first tick");
endmodule
`default_nettype wire

// file: verif/motor_stage_model.sv
// behavioural power stage with current, speed and position sensors
`timescale 1ns/1ps
`default_nettype none
module motor_stage_model (
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire logic signed [15:0] i_pwm,
  input  wire logic signed [15:0] i_load,
  output logic signed [15:0]      o_cur,
  output logic signed [15:0]      o_vel,
  output logic signed [15:0]      o_pos
);
  // current follows the bench load so expectations stay exact
  always_ff @(posedge i_clk) begin
    o_cur <= i_load;
    o_vel <= i_rst ? 16'sh0 : o_vel + (i_pwm >>> 10);
    o_pos <= i_rst ? 16'sh0 : o_pos + o_vel;
  end
endmodule
`default_nettype wire

// file: verif/tb.sv
// self-checking bench for the cascaded motor loop
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pi_loop_pkg::*;
  logic                I_MCLK     = 1'b0;
  logic                I_RST      = 1'b1;
  logic [7:0]          I_ADDR     = 8'h0;
  logic [31:0]         I_WDATA    = 32'h0;
  logic                I_WR       = 1'b0;
  logic                I_RD       = 1'b0;
  logic                I_STEP     = 1'b0;
  logic                I_DIR      = 1'b0;
  logic signed [15:0]  I_RAMP_VEL = 16'sh0;
  logic signed [15:0]  I_RAMP_ACC = 16'sh0;
  logic signed [15:0]  load       = 16'sh0;
  logic [31:0]         seed       = 32'hac56035f;
  logic [31:0]         r;
  logic [31:0]         m [0:63];
  int                  errors     = 0;
  int                  num_checks = 0;
  wire logic [31:0]    O_RDATA;
  wire logic signed [15:0] O_PWM;
  wire logic signed [15:0] I_POS_FB;
  wire logic signed [15:0] I_VEL_FB;
  wire logic signed [15:0] I_CUR_FB;
  wire logic           O_LOOP_CLOSED;
  always #4 I_MCLK = ~I_MCLK;
  cascaded_pi_motor_loop #(.DW(16)) uut (.I_MCLK, .I_RST, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .I_POS_FB,
    .I_VEL_FB, .I_CUR_FB, .I_STEP, .I_DIR, .I_RAMP_VEL, .I_RAMP_ACC, .O_PWM, .O_LOOP_CLOSED);
  motor_stage_model stage (.i_clk(I_MCLK), .i_rst(I_RST), .i_pwm(O_PWM), .i_load(load), .o_cur(I_CUR_FB),
    .o_vel(I_VEL_FB), .o_pos(I_POS_FB));
  // ---------------------------------------------------------------
  // model and helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic mapped(input logic [7:0] a);
    return a <= 8'h04 || (a >= 8'h10 && a <= 8'h48) || (a >= 8'h50 && a <= 8'h64);
  endfunction
  function automatic logic [31:0] rv(input logic [7:0] a);
    if (a == 8'h00) return 32'h30000;
    if (a >= 8'h10 && a < 8'h40) return a[3:2] == 2'h2 ? 32'h7fff : (a[3:2] == 2'h3 ? 32'h0 : 32'h3e8);
    if (a >= 8'h40 && a <= 8'h48) return 32'h1f4;
    if (a == 8'h5c) return 32'h3e8;
    return (a == 8'h60 || a == 8'h64) ? 32'h1 : 32'h0;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    I_ADDR  <= a;
    I_WDATA <= d;
    I_WR    <= 1'b1;
    @(posedge I_MCLK);
    I_WR <= 1'b0;
    // clearing the active legacy select copies legacy gains over
    if (a == 8'h00 && m[0][m[0][8] ? 16 : 17] && !d[d[8] ? 16 : 17])
      for (int n = 0; n < 3; n++) m[4 * n + 4] = m[16 + n];
    if (mapped(a)) m[a[7:2]] = d & ((a == 8'h00) ? 32'h3ffff : 32'hffff);
    @(posedge I_MCLK);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    I_ADDR <= a;
    I_RD   <= 1'b1;
    @(posedge I_MCLK);
    I_RD <= 1'b0;
    #1 q = O_RDATA;
    @(posedge I_MCLK);
  endtask
  task automatic sweep();
    logic [31:0] q;
    for (int a = 0; a < 8'h74; a += 4) begin
      rd(8'(a), q);
      check(q, m[a / 4]);
    end
    rd(8'hf0, q);
    check(q, 32'h0);
  endtask
  task automatic ticks(input int n);
    repeat (n * 1000) @(posedge I_MCLK);
  endtask
  // open loop: current set point is the speed loop limit
  task automatic pwm_case(input int kp, input int tn, input int y1, input int y2, input int uff, input int fb);
    int          p;
    logic [31:0] q;
    load <= 16'(fb);
    wr(8'h30, 32'(kp));
    wr(8'h3c, 32'(tn));
    wr(8'h28, 32'(y1));
    wr(8'h38, 32'(y2));
    wr(8'h5c, 32'(uff));
    ticks(3);
    p = (y1 - fb) * kp * y2 / 1000000;
    p = (p > y2) ? y2 : p;
    p = p + uff * y1 / 1000;
    p = (p > y2) ? y2 : p;
    #1 check({16'h0, O_PWM}, {16'h0, 16'(p)});
    rd(8'h7c, q);
    check(q, {16'h0, 16'(p)});
  endtask
  task automatic finish_test();
    if (errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------
  always @(posedge I_MCLK) begin
    r = xs();
    I_RAMP_VEL <= r[15:0];
    I_RAMP_ACC <= r[31:16];
    I_STEP     <= r[3];
    I_DIR      <= r[7];
  end
  initial begin
    #800000;
    errors++;
    finish_test();
  end
  initial begin
    logic [31:0] q;
    for (int i = 0; i < 64; i++) m[i] = rv(8'(i * 4));
    repeat (20) @(posedge I_MCLK);
    I_RST <= 1'b0;
    @(posedge I_MCLK);
    sweep();
    for (int a = 4; a < 8'h74; a += 4) wr(8'(a), xs());
    wr(8'hf0, xs());
    sweep();
    wr(8'h00, 32'h30100);
    #1 check({31'h0, O_LOOP_CLOSED}, 32'h1);
    wr(8'h00, 32'h30000);
    #1 check({31'h0, O_LOOP_CLOSED}, 32'h0);
    wr(8'h00, 32'h10000);
    sweep();
    wr(8'h50, 32'h0);
    wr(8'h54, 32'h0);
    wr(8'h34, 32'h3e8);
    pwm_case(1000, 0, 500, 1000, 0, 0);
    pwm_case(500, 0, 500, 1000, 0, 0);
    pwm_case(0, 0, 500, 32767, 1000, 0);
    pwm_case(0, 0, 500, 200, 1000, 0);
    pwm_case(0, 0, 500, 1000, 0, 0);
    for (int i = 0; i < 6; i++) pwm_case(xs() % 1001, 0, 500, 1000, xs() % 1001, xs() % 500);
    pwm_case(1000, 0, 200, 1000, 0, 100);
    wr(8'h3c, 32'h4);
    // pwm lags the current stage by one tick, so wait three
    ticks(3);
    #1 q = {16'h0, O_PWM};
    ticks(1);
    #1 check({31'h0, O_PWM > q[15:0] && q[15:0] > 16'h64}, 32'h1);
    wr(8'h3c, 32'h0);
    ticks(3);
    #1 check({16'h0, O_PWM}, 32'h64);
    finish_test();
  end
endmodule
bind cascaded_pi_motor_loop pi_loop_asserts #(.DW(DW)) chk (.I_MCLK, .I_RST, .I_ADDR, .I_WDATA, .I_WR, .I_RD,
  .O_RDATA, .I_POS_FB, .I_VEL_FB, .I_CUR_FB, .I_STEP, .I_DIR, .I_RAMP_VEL, .I_RAMP_ACC, .O_PWM, .O_LOOP_CLOSED);
`default_nettype wire
